/* hdl/result_formatter.sv */
`timescale 1ns/1ps
module result_formatter
  import sensor_cmd_pkg::*;
(
  input  wire logic     aclk,           // Clock
  input  wire logic     aresetn,        // Sync reset, low
  input  wire logic     sample_strobe,  // New sample pulse
  input  wire logic [31:0] air_quality_index,       // Index x10 input
  input  wire logic [31:0] organic_total,           // Raw organic value
  input  wire logic [31:0] alcohol_equivalent,      // Raw alcohol value
  input  wire logic [31:0] carbon_dioxide_estimate, // Raw CO2 value
  input  wire logic [31:0] relative_air_index,      // Relative index
  input  sensor_cmd_pkg::op_mode_t mode, // Current mode
  output logic [63:0] res_bytes,        // Fields, byte 0 first
  output logic [3:0]  res_len           // Field byte count
);
  import sensor_cmd_pkg::*;

  logic [7:0]  aqi_f;
  logic [15:0] org_f;
  logic [15:0] alc_f;
  logic [15:0] co2_f;
  logic [7:0]  rel_f;
  logic [15:0] org_b;
  logic [15:0] alc_b;

  // Snapshot of scaled and capped fields per sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aqi_f <= 8'h00;
      org_f <= 16'h0000;
      alc_f <= 16'h0000;
      co2_f <= 16'h0000;
      rel_f <= 8'h00;
      org_b <= 16'h0000;
      alc_b <= 16'h0000;
    end else if (sample_strobe) begin
      aqi_f <= sat8(air_quality_index / DIV_AIR_INDEX);
      org_f <= sat16(organic_total / DIV_ORGANIC);
      alc_f <= sat16(alcohol_equivalent / DIV_ORGANIC);
      co2_f <= sat16(carbon_dioxide_estimate);
      rel_f <= (relative_air_index > 32'h0000_0019) ? 8'hFF :
               8'(relative_air_index * MUL_RELATIVE);
      org_b <= sat16(organic_total / DIV_BUILDING);
      alc_b <= sat16(alcohol_equivalent / DIV_BUILDING);
    end
  end

  // Layout by mode, two-byte fields low byte first
  wire logic is_air  = (mode == OP_AIR) || (mode == OP_LOW_POWER);
  wire logic is_bldg = (mode == OP_BUILDING);
  assign res_bytes = is_air  ? {rel_f, co2_f, alc_f, org_f, aqi_f} :
                     is_bldg ? {32'h0000_0000, alc_b, org_b} :
                               64'h0;
  assign res_len   = is_air ? LEN_AIR : (is_bldg ? LEN_BUILDING : 4'h0);

  AST_SAT8: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_strobe && (air_quality_index > 32'h0000_09FF)
      |=> aqi_f == 8'hFF)
    else $error("air index field did not saturate");

  AST_BLDG_LAYOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    is_bldg |-> (res_len == LEN_BUILDING) && (res_bytes[63:32] == 32'h0))
    else $error("building layout wrong");

endmodule : result_formatter

/* hdl/sensor_cmd_core.sv */
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module sensor_cmd_core
  import sensor_cmd_pkg::*;
#(
  parameter longint unsigned CLEAN_CYCLES = sensor_cmd_pkg::CLEAN_CYCLES_DEF
)(
  input  wire logic        aclk,          // Clock, 100 MHz
  input  wire logic        aresetn,       // Sync reset, low
  input  wire logic [7:0]  awaddr,        // Write address
  input  wire logic        awvalid,       // Write address valid
  output logic             awready,       // Write address ready
  input  wire logic [31:0] wdata,         // Write data
  input  wire logic [3:0]  wstrb,         // Write strobes
  input  wire logic        wvalid,        // Write data valid
  output logic             wready,        // Write data ready
  output logic [1:0]       bresp,         // Write response
  output logic             bvalid,        // Write response valid
  input  wire logic        bready,        // Write response ready
  input  wire logic [7:0]  araddr,        // Read address
  input  wire logic        arvalid,       // Read address valid
  output logic             arready,       // Read address ready
  output logic [31:0]      rdata,         // Read data
  output logic [1:0]       rresp,         // Read response
  output logic             rvalid,        // Read data valid
  input  wire logic        rready,        // Read data ready
  input  wire logic        sample_strobe, // New sample from engine
  input  wire logic [31:0] air_quality_index,       // Index x10
  input  wire logic [31:0] organic_total,           // Organic value
  input  wire logic [31:0] alcohol_equivalent,      // Alcohol value
  input  wire logic [31:0] carbon_dioxide_estimate, // CO2 value
  input  wire logic [31:0] relative_air_index,      // Relative index
  output logic             meas_active,   // Measuring mode active
  output logic             meas_start,    // Measurement start pulse
  output logic [7:0]       op_mode_code,  // Current mode byte
  output logic [7:0]       humidity_code, // Stored humidity code
  output logic             alert_n,       // Host alert pin, low active
  input  wire logic [3:0]  port_pin_in,   // Levels of pins 1 to 4
  output logic [1:0]       port_pin_out,  // Drive value pins 1, 2
  output logic [1:0]       port_pin_oe    // Output enable pins 1, 2
);
  import sensor_cmd_pkg::*;

  localparam logic [39:0] CLEAN_LAST = 40'(CLEAN_CYCLES - 1);

  // Bus state
  logic        aw_held, w_held;
  logic [7:0]  waddr;
  logic [31:0] wbuf;
  logic [3:0]  wsel;
  // Request collection
  logic [1:0]  req_cnt;
  logic [7:0]  req_code, req_param, req_sum;
  logic        exec, exec_ok;
  // Response buffer
  logic [7:0]  resp_mem [0:15];
  logic [3:0]  resp_len, resp_rd;
  // Device state
  op_mode_t    mode;
  logic        clean_done;
  logic [39:0] clean_cnt;
  logic [7:0]  sample_cnt;
  logic [1:0]  pin_dir, pin_val;
  logic [63:0] res_bytes;
  logic [3:0]  res_len;

  // Write channel decode
  wire logic do_write = aw_held && w_held && !bvalid;
  wire logic wr_req   = do_write && (waddr == REQ_OFFSET);
  wire logic wr_known = (waddr == REQ_OFFSET) || (waddr == RESP_OFFSET) ||
                        (waddr == STATUS_OFFSET);
  wire logic req_push = wr_req && wsel[0];
  wire logic [7:0] push_byte = wbuf[7:0];
  wire logic [7:0] cur_code  = (req_cnt == 2'd0) ? push_byte : req_code;
  wire logic [1:0] last_idx  = param_count(cur_code) ? 2'd2 : 2'd1;
  wire logic req_last = req_push && (req_cnt == last_idx);
  wire logic [7:0] next_sum = (req_cnt == 2'd0) ? push_byte :
                              8'(req_sum + push_byte);
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;

  // Read channel decode
  wire logic rd_take  = arvalid && arready;
  wire logic rd_resp  = rd_take && (araddr[7:2] == RESP_OFFSET[7:2]);
  wire logic resp_has = resp_rd < resp_len;
  wire logic [31:0] status_word = {7'h00, clean_done, humidity_code,
                                   op_mode_code, 3'h0, req_cnt != 2'd0,
                                   4'(resp_len - resp_rd)};
  wire logic [31:0] resp_word = resp_has ?
      {23'h0, 1'b1, resp_mem[resp_rd]} : {24'h0, EMPTY_BYTE};
  assign arready = !rvalid;

  // Command decode
  wire logic known_cmd = (req_code == CMD_GET_MODE) ||
      (req_code == CMD_SET_MODE) || (req_code == CMD_SET_HUM) ||
      (req_code == CMD_GET_RESULT) || (req_code == CMD_PIN_DIR) ||
      (req_code == CMD_PIN_READ) || (req_code == CMD_PIN_SET) ||
      (req_code == CMD_PIN_CLEAR);
  wire logic good     = exec && exec_ok && known_cmd;
  wire logic cmd_mode = good && (req_code == CMD_SET_MODE);
  wire logic cmd_res  = good && (req_code == CMD_GET_RESULT);
  wire logic clean_end = (mode == OP_CLEANING) && (clean_cnt == CLEAN_LAST);
  wire op_mode_t asked = decode_mode(req_param);
  wire op_mode_t new_mode = (asked == OP_CLEANING &&
      (clean_done || clean_end)) ? OP_SUSPEND : asked;
  wire logic measuring = (mode == OP_AIR) || (mode == OP_LOW_POWER) ||
                         (mode == OP_BUILDING);
  wire logic new_meas  = (new_mode == OP_AIR) ||
      (new_mode == OP_LOW_POWER) || (new_mode == OP_BUILDING);

  // Response parameters by command
  logic [71:0] par;
  logic [3:0]  par_n;
  always_comb begin
    par   = 72'h0;
    par_n = 4'h0;
    if (good) begin
      unique case (req_code)
        CMD_GET_MODE: begin
          par[7:0] = op_mode_code;
          par_n    = 4'h1;
        end
        CMD_PIN_READ: begin
          par[7:0] = {4'h0, port_pin_in};
          par_n    = 4'h1;
        end
        CMD_GET_RESULT: begin
          par   = {res_bytes, sample_cnt};
          par_n = 4'(res_len + 4'h1);
        end
        default: par_n = 4'h0;
      endcase
    end
  end
  wire logic [7:0] status_byte = {exec && exec_ok && !known_cmd,
                                  exec && !exec_ok, 6'h00};
  wire logic [7:0] resp_cks =
      ~byte_sum({par, status_byte}, 4'(par_n + 4'h1));

  result_formatter u_fmt (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .sample_strobe           (sample_strobe),
    .air_quality_index       (air_quality_index),
    .organic_total           (organic_total),
    .alcohol_equivalent      (alcohol_equivalent),
    .carbon_dioxide_estimate (carbon_dioxide_estimate),
    .relative_air_index      (relative_air_index),
    .mode                    (mode),
    .res_bytes               (res_bytes),
    .res_len                 (res_len)
  );

  // Bus write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      waddr   <= 8'h00;
      wbuf    <= 32'h0;
      wsel    <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        waddr   <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wbuf   <= wdata;
        wsel   <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_known ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Bus read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= 2'b00;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata  <= (araddr[7:2] == RESP_OFFSET[7:2])   ? resp_word :
                (araddr[7:2] == STATUS_OFFSET[7:2]) ? status_word : 32'h0;
      rresp  <= (araddr[7:2] == RESP_OFFSET[7:2] ||
                 araddr[7:2] == STATUS_OFFSET[7:2] ||
                 araddr[7:2] == REQ_OFFSET[7:2]) ? 2'b00 : 2'b10;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Request byte collection and checksum test
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_cnt   <= 2'd0;
      req_code  <= 8'h00;
      req_param <= 8'h00;
      req_sum   <= 8'h00;
      exec      <= 1'b0;
      exec_ok   <= 1'b0;
    end else begin
      exec <= req_last;
      if (req_push) begin
        req_cnt <= req_last ? 2'd0 : 2'(req_cnt + 2'd1);
        req_sum <= next_sum;
        if (req_cnt == 2'd0) req_code <= push_byte;
        if (req_cnt == 2'd1 && !req_last) req_param <= push_byte;
        if (req_last) exec_ok <= (next_sum == SUM_TARGET);
      end
    end
  end

  // Response buffer load and pop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_len <= 4'h0;
      resp_rd  <= 4'h0;
    end else if (exec) begin
      resp_mem[0] <= status_byte;
      for (int i = 0; i < 9; i++) begin
        resp_mem[i + 1] <= par[8*i +: 8];
      end
      resp_mem[par_n + 4'h1] <= resp_cks;
      resp_len <= 4'(par_n + 4'h2);
      resp_rd  <= 4'h0;
    end else if (rd_resp && resp_has) begin
      resp_rd <= 4'(resp_rd + 4'h1);
    end
  end

  // Mode, cleaning timer and sample counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode       <= OP_SUSPEND;
      clean_done <= 1'b0;
      clean_cnt  <= 40'h0;
      sample_cnt <= 8'h00;
      meas_start <= 1'b0;
    end else begin
      meas_start <= cmd_mode && new_meas;
      if (clean_end) clean_done <= 1'b1;
      if (cmd_mode) begin
        mode       <= new_mode;
        clean_cnt  <= 40'h0;
        sample_cnt <= 8'h00;
      end else begin
        if (clean_end) mode <= OP_SUSPEND;
        clean_cnt <= (mode == OP_CLEANING) ? 40'(clean_cnt + 40'h1) : 40'h0;
        if (sample_strobe && measuring) begin
          sample_cnt <= 8'(sample_cnt + 8'h01);
        end
      end
    end
  end

  // Humidity, alert pin and port pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      humidity_code <= HUMIDITY_RESET;
      alert_n       <= 1'b1;
      pin_dir       <= 2'b00;
      pin_val       <= 2'b00;
    end else begin
      if (cmd_mode || cmd_res) begin
        alert_n <= 1'b0;
      end else if (sample_strobe && measuring) begin
        alert_n <= 1'b1;
      end
      if (good && req_code == CMD_SET_HUM) humidity_code <= req_param;
      if (good && req_code == CMD_PIN_DIR) pin_dir <= req_param[1:0];
      if (good && req_code == CMD_PIN_SET) begin
        pin_val <= pin_val | req_param[1:0];
      end
      if (good && req_code == CMD_PIN_CLEAR) begin
        pin_val <= pin_val & ~req_param[1:0];
      end
    end
  end

  assign op_mode_code = mode_code(mode);
  assign meas_active  = measuring;
  assign port_pin_out = pin_val;
  assign port_pin_oe  = pin_dir;   // Pins 3 and 4 have no driver

  AST_RESET_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> op_mode_code == MODE_SUSPEND)
    else $error("mode not suspend after reset");

  AST_ALERT_MODE: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_mode |=> !alert_n)
    else $error("alert not low after mode command");

  AST_ALERT_RESULT: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_res |=> !alert_n ##1 (!alert_n || $past(sample_strobe)))
    else $error("alert not low after result command");

  AST_CLEAN_ONCE: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_mode && clean_done && req_param == MODE_CLEANING
      |=> op_mode_code == MODE_SUSPEND)
    else $error("cleaning ran twice");

  AST_CLEAN_END: assert property (@(posedge aclk) disable iff (!aresetn)
    clean_end && !cmd_mode |=> (mode == OP_SUSPEND) && clean_done)
    else $error("cleaning did not end");

  AST_SAMPLE_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_mode |=> sample_cnt == 8'h00 ##1
      (sample_cnt == 8'h00 || $past(sample_strobe)))
    else $error("sample counter not cleared");

  AST_PIN_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    good && req_code == CMD_PIN_DIR |=> port_pin_oe == $past(req_param[1:0]))
    else $error("pin direction not applied");

  AST_PIN_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    good && req_code == CMD_PIN_READ
      |=> resp_mem[1] == {4'h0, $past(port_pin_in)} && resp_len == 4'h3)
    else $error("pin read byte wrong");

  AST_RESP_SUM: assert property (@(posedge aclk) disable iff (!aresetn)
    exec |=> 8'(resp_mem[0] + byte_sum({resp_mem[10], resp_mem[9], resp_mem[8],
      resp_mem[7], resp_mem[6], resp_mem[5], resp_mem[4], resp_mem[3],
      resp_mem[2], resp_mem[1]}, 4'(resp_len - 4'h1))) == SUM_TARGET)
    else $error("response checksum wrong");

  AST_BAD_SUM: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && !exec_ok |=> resp_mem[0][STAT_CHECKSUM_BIT] && resp_len == 4'h2)
    else $error("checksum error not reported");

endmodule : sensor_cmd_core

/* hdl/sensor_cmd_pkg.sv */
package sensor_cmd_pkg;

  // Command codes
  localparam logic [7:0] CMD_GET_MODE   = 8'h10;
  localparam logic [7:0] CMD_SET_MODE   = 8'h11;
  localparam logic [7:0] CMD_SET_HUM    = 8'h12;
  localparam logic [7:0] CMD_GET_RESULT = 8'h18;
  localparam logic [7:0] CMD_PIN_DIR    = 8'h20;
  localparam logic [7:0] CMD_PIN_READ   = 8'h21;
  localparam logic [7:0] CMD_PIN_SET    = 8'h22;
  localparam logic [7:0] CMD_PIN_CLEAR  = 8'h23;

  // Mode byte codes
  localparam logic [7:0] MODE_SUSPEND   = 8'h00;
  localparam logic [7:0] MODE_AIR       = 8'h01;
  localparam logic [7:0] MODE_LOW_POWER = 8'h02;
  localparam logic [7:0] MODE_BUILDING  = 8'h05;
  localparam logic [7:0] MODE_CLEANING  = 8'h80;

  // Status byte bits
  localparam int STAT_INVALID_BIT  = 7;
  localparam int STAT_CHECKSUM_BIT = 6;

  // Register byte offsets and fields
  localparam logic [7:0] REQ_OFFSET    = 8'h00;
  localparam logic [7:0] RESP_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam int RESP_VALID_BIT = 8;
  localparam int STAT_BUSY_BIT  = 4;
  localparam int STAT_MODE_LSB  = 8;
  localparam int STAT_HUM_LSB   = 16;
  localparam int STAT_CLEAN_BIT = 24;

  // Reset, empty-read and checksum values
  localparam logic [7:0] HUMIDITY_RESET = 8'h7F;
  localparam logic [7:0] EMPTY_BYTE     = 8'hFF;
  localparam logic [7:0] SUM_TARGET     = 8'hFF;

  // Result scaling and limits
  localparam int RES_MAX_BYTES = 8;
  localparam int DIV_AIR_INDEX = 10;
  localparam int DIV_ORGANIC   = 100;
  localparam int DIV_BUILDING  = 1000;
  localparam int MUL_RELATIVE  = 10;
  localparam logic [3:0] LEN_AIR      = 4'h8;
  localparam logic [3:0] LEN_BUILDING = 4'h4;

  // Cleaning duration
  localparam longint unsigned CLEAN_TIME_S = 60;
  localparam longint unsigned CLK_FREQ_HZ  = 100_000_000;
  localparam longint unsigned CLEAN_CYCLES_DEF = CLEAN_TIME_S * CLK_FREQ_HZ;

  typedef enum logic [2:0] {
    OP_SUSPEND, OP_AIR, OP_LOW_POWER, OP_BUILDING, OP_CLEANING
  } op_mode_t;

  // Request parameter count of a command
  function automatic logic param_count(input logic [7:0] code);
    return (code == CMD_SET_MODE) || (code == CMD_SET_HUM) ||
           (code == CMD_PIN_DIR) || (code == CMD_PIN_SET) ||
           (code == CMD_PIN_CLEAR);
  endfunction : param_count

  // Mode byte to mode
  function automatic op_mode_t decode_mode(input logic [7:0] b);
    unique case (b)
      MODE_AIR:       return OP_AIR;
      MODE_LOW_POWER: return OP_LOW_POWER;
      MODE_BUILDING:  return OP_BUILDING;
      MODE_CLEANING:  return OP_CLEANING;
      default:        return OP_SUSPEND;
    endcase
  endfunction : decode_mode

  // Mode to reported byte
  function automatic logic [7:0] mode_code(input op_mode_t m);
    unique case (m)
      OP_AIR:       return MODE_AIR;
      OP_LOW_POWER: return MODE_LOW_POWER;
      OP_BUILDING:  return MODE_BUILDING;
      OP_CLEANING:  return MODE_CLEANING;
      default:      return MODE_SUSPEND;
    endcase
  endfunction : mode_code

  // Saturating narrowing
  function automatic logic [7:0] sat8(input logic [31:0] v);
    return (v > 32'h0000_00FF) ? 8'hFF : v[7:0];
  endfunction : sat8

  function automatic logic [15:0] sat16(input logic [31:0] v);
    return (v > 32'h0000_FFFF) ? 16'hFFFF : v[15:0];
  endfunction : sat16

  // Low byte sum of the first n bytes
  function automatic logic [7:0] byte_sum(input logic [79:0] v,
                                          input logic [3:0]  n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 10; i++) begin
      if (4'(i) < n) begin
        s = s + v[8*i +: 8];
      end
    end
    return s;
  endfunction : byte_sum

endpackage : sensor_cmd_pkg

/* test/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner (
  input  wire logic [1:0] port_pin_out, // Device drive values
  input  wire logic [1:0] port_pin_oe,  // Device drive enables
  input  wire logic [3:0] ext_level,    // Far-side drive levels
  output logic      [3:0] port_pin_in   // Resolved pin levels
);
  // Device wins where it drives, far side holds the rest
  assign port_pin_in = {ext_level[3:2],
    port_pin_oe[1] ? port_pin_out[1] : ext_level[1],
    port_pin_oe[0] ? port_pin_out[0] : ext_level[0]};
endmodule : pin_partner

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import sensor_cmd_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sample_strobe;
  logic        alert_n, meas_active, meas_start;
  logic [7:0]  awaddr, araddr, op_mode_code, humidity_code;
  logic [31:0] wdata, rdata, d, air_quality_index, organic_total;
  logic [31:0] alcohol_equivalent, carbon_dioxide_estimate;
  logic [31:0] relative_air_index;
  logic [3:0]  wstrb, port_pin_in, ext_level;
  logic [1:0]  bresp, rresp, rr, port_pin_out, port_pin_oe;
  logic [7:0]  mi [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h05, 8'h7F};
  logic [7:0]  mo [7] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h05, 8'h00};
  int          errors, checks_done;
  int          starts = 0;

  sensor_cmd_core #(.CLEAN_CYCLES(20)) i_sensor_cmd_core (.*);
  pin_partner i_pin_partner (.*);

  // Counts measurement start pulses
  always @(posedge aclk) if (meas_start === 1'b1) starts <= starts + 1;

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task report_and_stop;
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // One edge with a bound on the whole wait
  task tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      errors++;
      report_and_stop();
    end
  endtask : tick

  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      tick(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rr = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      tick(n);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Frame with checksum, then wait for the response to load
  task cmd(input logic [7:0] c, input logic [7:0] p, input bit np);
    wr(8'h00, {24'h0, c});
    if (np) wr(8'h00, {24'h0, p});
    wr(8'h00, {24'h0, ~(c + (np ? p : 8'h00))});
    repeat (2) @(posedge aclk);
  endtask : cmd

  // Pops n bytes, the checksum, then expects an empty queue
  task rsp(input logic [79:0] v, input int n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++) begin
      rd(8'h04, d);
      chk({23'h0, 1'b1, v[8*i +: 8]}, d);
      s = s + v[8*i +: 8];
    end
    rd(8'h04, d);
    chk({23'h0, 1'b1, ~s}, d);
    rd(8'h04, d);
    chk(32'h0000_00FF, d);
  endtask : rsp

  task smp;
    sample_strobe <= 1'b1;
    @(posedge aclk);
    sample_strobe <= 1'b0;
    @(posedge aclk);
  endtask : smp

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sample_strobe} = 6'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
    air_quality_index = 32'h1388; organic_total = 32'h3039;
    alcohol_equivalent = 32'h0098_9680; carbon_dioxide_estimate = 32'h320;
    relative_air_index = 32'h3; ext_level = 4'hA;
    aresetn = 1'b0; errors = 0; checks_done = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h08, d); chk(32'h007F_0000, d);
    rd(8'h0C, d); chk(32'h2, 32'(rr));
    wr(8'h0C, 32'h0); chk(32'h2, 32'(rr));
    for (int i = 0; i < 7; i++) begin
      cmd(8'h11, mi[i], 1); chk(32'(mo[i]), 32'(op_mode_code));
      chk(32'(mo[i] != 8'h00), 32'(meas_active));
      chk(32'h0, 32'(alert_n));
      cmd(8'h10, 8'h00, 0); rsp({mo[i], 8'h00}, 2);
    end
    cmd(8'h11, 8'h01, 1); smp(); chk(32'h1, 32'(alert_n));
    cmd(8'h18, 8'h00, 0); chk(32'h0, 32'(alert_n));
    rsp(80'h1E_0320_FFFF_007B_FF_01_00, 10);
    cmd(8'h11, 8'h05, 1); smp(); smp(); cmd(8'h18, 8'h00, 0);
    rsp(80'h2710_000C_02_00, 6);
    cmd(8'h12, 8'hCC, 1); chk(32'hCC, 32'(humidity_code));
    // Corrupt checksum: no action, status only
    wr(8'h00, 32'h12); wr(8'h00, 32'h33); wr(8'h00, 32'h00);
    repeat (2) @(posedge aclk);
    chk(32'hCC, 32'(humidity_code)); rsp(80'h40, 1);
    cmd(8'h21, 8'h00, 0); rsp(80'h0A00, 2);
    cmd(8'h20, 8'hFF, 1); chk(32'h3, 32'(port_pin_oe));
    cmd(8'h22, 8'hFD, 1); chk(32'h1, 32'(port_pin_out));
    cmd(8'h21, 8'h00, 0); rsp(80'h0900, 2);
    cmd(8'h22, 8'h02, 1); chk(32'h3, 32'(port_pin_out));
    cmd(8'h23, 8'hFD, 1); chk(32'h2, 32'(port_pin_out));
    cmd(8'h11, 8'h80, 1); chk(32'h80, 32'(op_mode_code));
    cmd(8'h10, 8'h00, 0); rsp(80'h8000, 2);
    repeat (22) @(posedge aclk);
    chk(32'h0, 32'(op_mode_code));
    cmd(8'h10, 8'h00, 0); rsp(80'h0000, 2);
    rd(8'h08, d); chk(32'h01CC_0000, d);
    cmd(8'h11, 8'h80, 1); chk(32'h0, 32'(op_mode_code));
    chk(32'd5, starts);
    report_and_stop();
  end
endmodule : testbench
